// >>> dual_pot_serial_shift_port.sv
`timescale 1ns/1ps
`include "dual_pot_params.svh"

module dual_pot_serial_shift_port
	import dual_pot_pkg::*;
#(
	parameter int SHIFT_BITS = `SHIFT_BITS,
	parameter int CODE_BITS  = `CODE_BITS,
	parameter int TAP_COUNT  = `TAP_COUNT
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  port_enable,
	input  wire logic                  serial_clk,
	input  wire logic                  serial_data_in,
	output logic                       cascade_out,
	output logic                       stack_select,
	output logic [CODE_BITS-1:0]       wiper_zero_code,
	output logic [CODE_BITS-1:0]       wiper_one_code,
	output logic [CODE_BITS-1:0]       stacked_wiper_out,
	output logic [TAP_COUNT-1:0]       wiper_zero_terminal,
	output logic [TAP_COUNT-1:0]       wiper_one_terminal
);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Bits arrive MSB first at the lower position, so a code is read reversed.
	function automatic logic [CODE_BITS-1:0] reverse_code(input logic [CODE_BITS-1:0] v);
		logic [CODE_BITS-1:0] r;
		r = '0;
		for (int i = 0; i < CODE_BITS; i++) begin
			r[i] = v[CODE_BITS-1-i];
		end
		return r;
	endfunction : reverse_code

	// One-hot tap decoder for a wiper code.
	function automatic logic [TAP_COUNT-1:0] tap_decode(input logic [CODE_BITS-1:0] c);
		logic [TAP_COUNT-1:0] t;
		t = '0;
		t[c] = 1'b1;
		return t;
	endfunction : tap_decode

	// Power-up register image: stack bit and both mid-scale codes.
	localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = {
		reverse_code(`WIPER_RESET), reverse_code(`WIPER_RESET), `STACK_RESET};

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge filters.

	logic [2:0]           en_sync_q;    // Enable synchroniser, stage 0 first.
	logic [2:0]           sck_sync_q;   // Serial clock synchroniser.
	logic [2:0]           dat_sync_q;   // Serial data synchroniser.
	logic                 en_f_q;       // Accepted enable level.
	logic                 sck_f_q;      // Accepted serial clock level.
	logic                 en_rise;      // Enable went high.
	logic                 en_fall;      // Enable went low.
	logic                 sck_rise;     // Serial clock rose.
	port_state_e          state_q;      // Port state.
	logic [SHIFT_BITS-1:0] shift_q;     // Serial shift register.
	logic [SHIFT_BITS-1:0] shift_d;     // Next shift register image.
	logic                 shift_fire;   // One accepted shift this cycle.

	// Every pin passes three flops; stage 0 feeds stage 1 only.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_sync_q  <= 3'h0;
			sck_sync_q <= 3'h0;
			dat_sync_q <= 3'h0;
		end else begin
			en_sync_q  <= {en_sync_q[1:0], port_enable};
			sck_sync_q <= {sck_sync_q[1:0], serial_clk};
			dat_sync_q <= {dat_sync_q[1:0], serial_data_in};
		end
	end

	// A level change counts only once stages one and two agree.
	assign en_rise  = (en_sync_q[1] == en_sync_q[2]) && en_sync_q[2] && !en_f_q;
	assign en_fall  = (en_sync_q[1] == en_sync_q[2]) && !en_sync_q[2] && en_f_q;
	assign sck_rise = (sck_sync_q[1] == sck_sync_q[2]) && sck_sync_q[2] && !sck_f_q;

	// Filtered levels follow the agreed synchroniser value.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_f_q  <= 1'b0;
			sck_f_q <= 1'b0;
		end else begin
			if (en_sync_q[1] == en_sync_q[2]) begin
				en_f_q <= en_sync_q[2];
			end
			if (sck_sync_q[1] == sck_sync_q[2]) begin
				sck_f_q <= sck_sync_q[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port state.

	// Only a low-to-high enable opens the port, so a clock edge that
	// arrives together with the enable rise is not taken.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= PORT_IDLE;
		end else begin
			unique case (state_q)
				PORT_IDLE: begin
					if (en_rise) begin
						state_q <= PORT_ACTIVE;
					end
				end
				PORT_ACTIVE: begin
					if (en_fall) begin
						state_q <= PORT_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift register and cascade output.

	// Shifting only while active and enable still high.
	assign shift_fire = (state_q == PORT_ACTIVE) && en_f_q && !en_fall && sck_rise;

	// New bits enter at the top and walk toward position zero.
	assign shift_d = {dat_sync_q[2], shift_q[SHIFT_BITS-1:1]};

	// Register holds stack bit and two codes; power-up image is mid-scale.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_q <= SHIFT_RESET;
		end else if (shift_fire) begin
			shift_q <= shift_d;
		end
	end

	// Cascade presents position zero at all times, so the stack bit leaves
	// first; it updates with the shift, about four cycles after the pin edge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cascade_out <= `STACK_RESET;
		end else if (shift_fire) begin
			cascade_out <= shift_d[`STACK_POS];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wiper registers, loaded only when enable falls.

	logic [CODE_BITS-1:0] pot0_new;  // Pot-0 code held in the register.
	logic [CODE_BITS-1:0] pot1_new;  // Pot-1 code held in the register.
	logic                 stack_new; // Stack bit held in the register.

	assign pot1_new  = reverse_code(shift_q[`POT1_MSB_POS +: CODE_BITS]);
	assign pot0_new  = reverse_code(shift_q[`POT0_MSB_POS +: CODE_BITS]);
	assign stack_new = shift_q[`STACK_POS];

	// Codes and stack bit move only on the enable fall.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wiper_zero_code <= `WIPER_RESET;
			wiper_one_code  <= `WIPER_RESET;
			stack_select    <= `STACK_RESET;
		end else if (en_fall) begin
			wiper_zero_code <= pot0_new;
			wiper_one_code  <= pot1_new;
			stack_select    <= stack_new;
		end
	end

	// Tap selects and stacked output are decoded from the values being
	// loaded, which costs gates but keeps every output on a flop.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wiper_zero_terminal <= tap_decode(`WIPER_RESET);
			wiper_one_terminal  <= tap_decode(`WIPER_RESET);
			stacked_wiper_out   <= `WIPER_RESET;
		end else if (en_fall) begin
			wiper_zero_terminal <= tap_decode(pot0_new);
			wiper_one_terminal  <= tap_decode(pot1_new);
			stacked_wiper_out   <= stack_new ? pot1_new : pot0_new;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	localparam int CASC_LIM = `CASCADE_CYCLES;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_load;
		en_fall;
	endsequence

	sequence s_shift;
		shift_fire;
	endsequence

	a_idle_no_shift: assert property ((state_q == PORT_IDLE) |=> $stable(shift_q))
		else $error("shift register moved while port idle");

	a_shift_step: assert property (s_shift |=>
		shift_q == {$past(dat_sync_q[2]), $past(shift_q[SHIFT_BITS-1:1])})
		else $error("shift step wrong");

	a_cascade_time: assert property (s_shift |-> ##[1:CASC_LIM]
		(cascade_out == shift_q[`STACK_POS]))
		else $error("cascade bit late");

	a_cascade_follow: assert property (##1 (cascade_out == shift_q[`STACK_POS]))
		else $error("cascade not tracking position zero");

	a_pot0_load: assert property (s_load |=>
		wiper_zero_code == reverse_code($past(shift_q[`POT0_MSB_POS +: CODE_BITS])))
		else $error("pot-0 load wrong");

	a_pot1_load: assert property (s_load |=>
		wiper_one_code == reverse_code($past(shift_q[`POT1_MSB_POS +: CODE_BITS])))
		else $error("pot-1 load wrong");

	a_stack_load: assert property (s_load |=> stack_select == $past(shift_q[`STACK_POS]))
		else $error("stack bit load wrong");

	a_wiper_hold: assert property (!en_fall |=>
		$stable(wiper_zero_code) && $stable(wiper_one_code) && $stable(stack_select))
		else $error("wiper changed outside enable fall");

	// Both tap selects are checked together, so the pair is one operand of the delay.
	a_tap_select: assert property (##1 (
		(wiper_zero_terminal == tap_decode(wiper_zero_code))
		&& (wiper_one_terminal == tap_decode(wiper_one_code))))
		else $error("tap select does not match code");

	a_stack_mux: assert property (##1 stacked_wiper_out ==
		(stack_select ? wiper_one_code : wiper_zero_code))
		else $error("stacked wiper routes wrong pot");

endmodule : dual_pot_serial_shift_port

// >>> dual_pot_params.svh
// Behaviour
// - Ignore serial activity while port enable low.
// - Sample data on each rising serial clock.
// - Seventeen-bit register: stack bit, two codes.
// - Position zero holds the stack select.
// - Positions one to eight: pot-1, MSB first.
// - Positions nine to sixteen: pot-0, MSB first.
// - Wipers load only when enable falls.
// - Power-up wiper codes are mid-scale.
// - Each code selects one of 256 taps.
// - Stack select picks pot-0 or pot-1 wiper.
// - Cascade bit appears within 50 ns.
// - Stack select bit shifts out first.
// - Cascade output driven at all times.
// - Readback loop restores contents on enable fall.
`ifndef DUAL_POT_PARAMS_SVH
`define DUAL_POT_PARAMS_SVH

// Shape of the serial shift register.
`define SHIFT_BITS      17
`define CODE_BITS       8
`define TAP_COUNT       256
`define STACK_POS       0
`define POT1_MSB_POS    1
`define POT0_MSB_POS    9

// Power-up values.
`define WIPER_RESET     8'h80
`define STACK_RESET     1'b0

// Cascade output timing.
`define CLK_PERIOD_NS   8
`define CASCADE_MAX_NS  50
`define CASCADE_CYCLES  (`CASCADE_MAX_NS / `CLK_PERIOD_NS)

`endif

// >>> dual_pot_pkg.sv
package dual_pot_pkg;

	// Port state; a Gray step separates idle and active.
	typedef enum logic [0:0] {
		PORT_IDLE   = 1'b0,
		PORT_ACTIVE = 1'b1
	} port_state_e;

	// One wiper code.
	typedef logic [7:0] code_t;

endpackage : dual_pot_pkg

// >>> serial_host.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Host side of the three-wire port; every pin moves just after a clk edge.
module serial_host (
	input  wire logic clk,
	input  wire logic cascade_in,
	output logic      port_enable,
	output logic      serial_clk,
	output logic      serial_data_in
);
	logic data_q;  // Bit presented while the host owns the data line.
	logic drive_q; // High while the host drives the data line.
	logic loop_q;  // High while the cascade output is looped back.
	logic junk_q;  // A released line wanders, so stale bits cannot pass.

	// All pins start low so nothing moves while reset is released.
	initial begin
		port_enable = 1'b0;
		serial_clk = 1'b0;
		data_q = 1'b0;
		drive_q = 1'b0;
		loop_q = 1'b0;
		junk_q = 1'b0;
	end

	// A floating data line toggles every cycle instead of holding its value.
	always @(posedge clk) begin
		junk_q <= ~junk_q;
	end

	assign serial_data_in = loop_q ? cascade_in : (drive_q ? data_q : junk_q);

	// Enable rises and settles before the first serial clock edge.
	task automatic start(input logic loop);
		port_enable <= 1'b1;
		loop_q <= loop;
		repeat (5) @(posedge clk);
	endtask : start

	// One bit: data set up a half period before the rise, held a half after.
	task automatic shift(input logic b);
		drive_q <= 1'b1;
		data_q <= b;
		repeat (5) @(posedge clk);
		serial_clk <= 1'b1;
		repeat (5) @(posedge clk);
		serial_clk <= 1'b0;
	endtask : shift

	// Enable drops at the end, and the wipers get time to load.
	task automatic stop();
		port_enable <= 1'b0;
		loop_q <= 1'b0;
		drive_q <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : stop
endmodule : serial_host

// >>> testbench.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module testbench
	import dual_pot_pkg::*;
;
	logic           clk;
	logic           arst_n = 1'b0;
	logic           port_enable;
	logic           serial_clk;
	logic           serial_data_in;
	logic           cascade_out;
	logic           stack_select;
	code_t          wiper_zero_code;
	code_t          wiper_one_code;
	code_t          stacked_wiper_out;
	logic [255:0]   wiper_zero_terminal;
	logic [255:0]   wiper_one_terminal;
	int             fails = 0;
	int             check_count = 0;
	logic           ws = 1'b0;  // Stack bit the device should hold.
	code_t          w1 = 8'h80; // Pot-1 code the device should hold.
	code_t          w0 = 8'h80; // Pot-0 code the device should hold.

	dual_pot_serial_shift_port dut (
		.clk(clk), .arst_n(arst_n), .port_enable(port_enable),
		.serial_clk(serial_clk), .serial_data_in(serial_data_in),
		.cascade_out(cascade_out), .stack_select(stack_select),
		.wiper_zero_code(wiper_zero_code), .wiper_one_code(wiper_one_code),
		.stacked_wiper_out(stacked_wiper_out),
		.wiper_zero_terminal(wiper_zero_terminal),
		.wiper_one_terminal(wiper_one_terminal)
	);

	serial_host host (
		.clk(clk), .cascade_in(cascade_out), .port_enable(port_enable),
		.serial_clk(serial_clk), .serial_data_in(serial_data_in)
	);

	// Free-running system clock, 8 ns period.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	// Register image: position 0 stack, then pot-1 and pot-0, MSB first.
	function automatic logic [16:0] img(input logic s, input code_t c1, input code_t c0);
		logic [16:0] r;
		r[0] = s;
		for (int i = 0; i < 8; i++) begin
			r[1 + i] = c1[7 - i];
			r[9 + i] = c0[7 - i];
		end
		return r;
	endfunction : img

	// Compare of the 256-bit one-hot tap selects.
	task automatic cmp_tap(input logic [255:0] got, input logic [255:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_tap

	// Compare of one 8-bit wiper code.
	task automatic cmp_code(input code_t got, input code_t exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_code

	// Compare of one single-bit output.
	task automatic cmp_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_bit

	// Every wiper-side output against the values the device should hold.
	task automatic check_wipers(input logic s, input code_t c1, input code_t c0);
		cmp_bit(stack_select, s);
		cmp_code(wiper_one_code, c1);
		cmp_code(wiper_zero_code, c0);
		cmp_code(stacked_wiper_out, s ? c1 : c0);
		cmp_tap(wiper_one_terminal, 256'h1 << c1);
		cmp_tap(wiper_zero_terminal, 256'h1 << c0);
	endtask : check_wipers

	// One 17-bit frame; in loop mode the old contents must come back.
	task automatic frame(input logic loop, input logic s, input code_t c1, input code_t c0);
		logic [33:0] q;
		q = {img(s, c1, c0), img(ws, w1, w0)};
		host.start(loop);
		cmp_bit(cascade_out, ws);
		for (int k = 0; k < 17; k++) begin
			host.shift(q[17 + k]);
			cmp_bit(cascade_out, q[k + 1]);
		end
		check_wipers(ws, w1, w0);
		host.stop();
		ws = s;
		w1 = c1;
		w0 = c0;
		check_wipers(s, c1, c0);
		cmp_bit(cascade_out, s);
	endtask : frame

	// Two images in one transfer, as for a chain of two devices: the far
	// image passes through and leaves on cascade for the next data input.
	task automatic chain(input logic [16:0] far, input logic s, input code_t c1, input code_t c0);
		logic [50:0] q;
		q = {img(s, c1, c0), far, img(ws, w1, w0)};
		host.start(1'b0);
		cmp_bit(cascade_out, ws);
		for (int k = 0; k < 34; k++) begin
			host.shift(q[17 + k]);
			cmp_bit(cascade_out, q[k + 1]);
		end
		check_wipers(ws, w1, w0);
		host.stop();
		ws = s;
		w1 = c1;
		w0 = c0;
		check_wipers(s, c1, c0);
	endtask : chain

	// Prints the verdict once and ends the run.
	task automatic give_verdict();
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////
	// A hung run counts as a failure.
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict();
	end

	// Corners first, then random frames, ignored clocks and readback.
	initial begin
		void'($urandom(93347));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check_wipers(1'b0, 8'h80, 8'h80);
		cmp_bit(cascade_out, 1'b0);
		frame(1'b0, 1'b1, 8'h00, 8'hff);
		frame(1'b0, 1'b0, 8'hff, 8'h00);
		frame(1'b1, ws, w1, w0);
		chain(17'($urandom), 1'b1, 8'($urandom), 8'($urandom));
		repeat (8) frame(1'b0, 1'($urandom), 8'($urandom), 8'($urandom));
		// A reset in mid-run must bring back the power-up image from any state.
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		ws = 1'b0;
		w1 = 8'h80;
		w0 = 8'h80;
		check_wipers(ws, w1, w0);
		cmp_bit(cascade_out, ws);
		// Clocks with the port disabled must leave everything alone.
		for (int k = 0; k < 17; k++) begin
			host.shift(1'($urandom));
		end
		cmp_bit(cascade_out, ws);
		host.start(1'b0);
		host.stop();
		check_wipers(ws, w1, w0);
		frame(1'b1, ws, w1, w0);
		give_verdict();
	end
endmodule : testbench
